// ### ivam_top.sv
// Purpose: reset and interrupt vector address generation for the core
// Assumes: requests arrive already masked by their enables and global flag
// Notes:   fetch address held until the core acknowledges it
//
// Summary of operation
// R1: unprogrammed fuse: every reset vectors to 0x0000
// R2: external irqs 0x02-0x06, pin change 0x08-0x0E
// R3: watchdog 0x10, timer2 0x12-0x16, timer1 0x18-0x1E
// R4: timer0 0x20-0x24, serial 0x26, uart0 0x28-0x2C
// R5: comparator to uart1: 0x2E through 0x3C
// R6: programmed fuse (0) resets to boot base
// R7: select bit set: interrupt vectors offset by boot base
// R8: fuse and select bit decode the placement
// R9: untaken vector words may hold code (software)
// R10: lowest vector first; reset beats interrupts
`timescale 1ns/1ps
`default_nettype none
module ivam_top
	import ivam_pkg::*;
#(
	parameter int unsigned N         = IVAM_NUM_IRQ,
	parameter logic [15:0] BOOT_BASE = IVAM_BOOT_BASE_DFLT
) (
	input  wire logic          core_clk,
	input  wire logic          srst,
	input  wire logic          boot_reset_fuse,
	input  wire logic          vector_table_select,
	input  wire logic [N-1:0]  irq_req,
	input  wire logic          fetch_ack,
	output ivam_fetch_t        fetch_r
);

	// ====================================================================
	// address arithmetic
	// word address of table vector n (0 = reset)
	function automatic logic [15:0] table_addr(input logic [IVAM_IDX_W:0] n);
		table_addr = 16'(n) * IVAM_VEC_STEP;
	endfunction

	function automatic logic [15:0] irq_addr(input logic [IVAM_IDX_W-1:0] idx,
		input logic sel, input logic [15:0] base);
		logic [15:0] t;
		t = table_addr({1'b0, idx} + 6'h01);
		irq_addr = sel ? 16'(t + base) : t; // R7 R8
	endfunction

	// ====================================================================
	// state
	ivam_state_t state_r, state_nxt;
	ivam_fetch_t fetch_nxt;
	logic        pick_hit;
	logic [IVAM_IDX_W-1:0] pick_idx;
	logic        busy;
	logic        gap_r;
	logic        gap_nxt;

	// the finder adds one register stage between a request and its issue
	ivam_pick #(.N(N)) u_pick (
		.core_clk (core_clk),
		.srst     (srst),
		.req      (irq_req),
		.hit_r    (pick_hit),
		.idx_r    (pick_idx)
	);

	assign busy = fetch_r.valid & ~fetch_ack;

	always_comb begin
		state_nxt = state_r;
		fetch_nxt = fetch_r;
		// a take starts a second idle cycle for the finder's stale hit
		gap_nxt   = fetch_r.valid & fetch_ack;
		case (state_r)
			IVAM_ST_RESET: begin
				// reset vector beats any pending interrupt
				// fuse taken once, so the address stands until the core takes it
				if (!fetch_r.valid) begin
					fetch_nxt.valid    = 1'b1; // R10
					fetch_nxt.is_reset = 1'b1;
					fetch_nxt.index    = '0;
					fetch_nxt.addr     = (boot_reset_fuse == IVAM_FUSE_PROG) ?
						BOOT_BASE : IVAM_RESET_VEC; // R1 R6 R8
				end else if (fetch_ack) begin
					fetch_nxt.valid = 1'b0;
					state_nxt       = IVAM_ST_RUN;
				end
			end
			IVAM_ST_RUN: begin
				if (!busy) begin
					// two idle edges after a take: the finder register must see the source drop
					fetch_nxt.valid    = pick_hit & ~fetch_r.valid & ~gap_r; // R10
					fetch_nxt.is_reset = 1'b0;
					fetch_nxt.index    = pick_idx;
					fetch_nxt.addr     = irq_addr(pick_idx, vector_table_select,
						BOOT_BASE); // R2 R3 R4 R5
				end
			end
			default: begin
				state_nxt = IVAM_ST_RESET;
				fetch_nxt = '0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= IVAM_ST_RESET;
			fetch_r <= '0;
			gap_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fetch_r <= fetch_nxt;
			gap_r   <= gap_nxt;
		end
	end

	// ====================================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence reset_issued;
		fetch_r.valid && fetch_r.is_reset;
	endsequence

	reset_addr_unprog_a: assert property ( // R1
		reset_issued ##0 boot_reset_fuse |-> fetch_r.addr == 16'h0000)
		else $error("reset vector not at word zero");

	reset_addr_prog_a: assert property ( // R6
		reset_issued ##0 !boot_reset_fuse |-> fetch_r.addr == BOOT_BASE)
		else $error("reset vector not at boot base");

	irq_first_a: assert property ( // R2
		fetch_r.valid && !fetch_r.is_reset && fetch_r.index == 0 &&
		!$past(vector_table_select) |-> fetch_r.addr == 16'h0002)
		else $error("first external irq vector wrong");

	irq_watchdog_a: assert property ( // R3
		fetch_r.valid && !fetch_r.is_reset && fetch_r.index == 5'd7 &&
		!$past(vector_table_select) |-> fetch_r.addr == 16'h0010)
		else $error("watchdog vector wrong");

	irq_serial_a: assert property ( // R4
		fetch_r.valid && !fetch_r.is_reset && fetch_r.index == 5'd18 &&
		!$past(vector_table_select) |-> fetch_r.addr == 16'h0026)
		else $error("serial vector wrong");

	irq_last_a: assert property ( // R5
		fetch_r.valid && !fetch_r.is_reset && fetch_r.index == 5'd29 &&
		!$past(vector_table_select) |-> fetch_r.addr == 16'h003C)
		else $error("last vector wrong");

	irq_moved_a: assert property ( // R7
		fetch_r.valid && !fetch_r.is_reset && $rose(fetch_r.valid) &&
		$past(vector_table_select) |->
		fetch_r.addr == 16'(BOOT_BASE + 16'(fetch_r.index) * 16'h0002 + 16'h0002))
		else $error("moved vector wrong");

	reset_first_a: assert property ( // R10
		$fell(srst) |=> fetch_r.valid && fetch_r.is_reset)
		else $error("reset vector not first");

	hold_until_ack_a: assert property ( // R10
		fetch_r.valid && !fetch_ack |=> $stable(fetch_r))
		else $error("fetch changed before ack");

	lowest_first_a: assert property ( // R10
		$rose(fetch_r.valid) && !fetch_r.is_reset && $past(irq_req[0], 2) |->
		fetch_r.index == 5'd0)
		else $error("lower vector not served first");

	// ====================================================================
	// flat-table vectors at the ends of several source groups
	sequence irq_flat_issued;
		$rose(fetch_r.valid) && !fetch_r.is_reset && !$past(vector_table_select);
	endsequence

	sequence vector_taken;
		fetch_r.valid && fetch_ack;
	endsequence

	ext_irq_last_a: assert property ( // R2
		irq_flat_issued ##0 fetch_r.index == 5'd2 |-> fetch_r.addr == 16'h0006)
		else $error("third external irq vector wrong");

	pin_change_first_a: assert property ( // R2
		irq_flat_issued ##0 fetch_r.index == 5'd3 |-> fetch_r.addr == 16'h0008)
		else $error("first pin change vector wrong");

	pin_change_last_a: assert property ( // R2
		irq_flat_issued ##0 fetch_r.index == 5'd6 |-> fetch_r.addr == 16'h000E)
		else $error("last pin change vector wrong");

	timer2_first_a: assert property ( // R3
		irq_flat_issued ##0 fetch_r.index == 5'd8 |-> fetch_r.addr == 16'h0012)
		else $error("timer2 compare vector wrong");

	timer1_last_a: assert property ( // R3
		irq_flat_issued ##0 fetch_r.index == 5'd14 |-> fetch_r.addr == 16'h001E)
		else $error("timer1 overflow vector wrong");

	timer0_first_a: assert property ( // R4
		irq_flat_issued ##0 fetch_r.index == 5'd15 |-> fetch_r.addr == 16'h0020)
		else $error("timer0 compare vector wrong");

	uart0_last_a: assert property ( // R4
		irq_flat_issued ##0 fetch_r.index == 5'd21 |-> fetch_r.addr == 16'h002C)
		else $error("uart0 transmit vector wrong");

	comparator_vec_a: assert property ( // R5
		irq_flat_issued ##0 fetch_r.index == 5'd22 |-> fetch_r.addr == 16'h002E)
		else $error("comparator vector wrong");

	store_ready_a: assert property ( // R5
		irq_flat_issued ##0 fetch_r.index == 5'd26 |-> fetch_r.addr == 16'h0036)
		else $error("program store ready vector wrong");

	// ====================================================================
	// one take per presentation, then a two-cycle idle gap
	taken_once_a: assert property ( // R10
		vector_taken |=> !fetch_r.valid)
		else $error("vector still presented after take");

	idle_gap_a: assert property ( // R10
		$fell(fetch_r.valid) |=> !fetch_r.valid)
		else $error("idle gap after take too short");

endmodule
`default_nettype wire

// ### ivam_pkg.sv
// Purpose: constants and types for the interrupt vector address map
// Assumes: word-addressed program memory, 16-bit fetch address
// Notes:   vector n (1-based) sits at table word 2*(n-1)
package ivam_pkg;

	// ====================================================================
	// widths and table layout
	localparam int unsigned IVAM_ADDR_W    = 16;
	localparam int unsigned IVAM_NUM_IRQ   = 30;
	localparam int unsigned IVAM_IDX_W     = 5;
	localparam logic [15:0] IVAM_RESET_VEC = 16'h0000;
	localparam logic [15:0] IVAM_FIRST_IRQ = 16'h0002;
	localparam logic [15:0] IVAM_VEC_STEP  = 16'h0002;
	localparam logic [15:0] IVAM_LAST_IRQ  = 16'h003C;
	localparam logic [15:0] IVAM_BOOT_BASE_DFLT = 16'hF000;
	localparam logic        IVAM_FUSE_PROG = 1'b0;

	// ====================================================================
	// request bit positions, in vector order
	localparam int unsigned IVAM_EXT_IRQ_0      = 0;
	localparam int unsigned IVAM_PIN_CHANGE_0   = 3;
	localparam int unsigned IVAM_WATCHDOG       = 7;
	localparam int unsigned IVAM_TIMER2_COMPA   = 8;
	localparam int unsigned IVAM_TIMER1_CAPT    = 11;
	localparam int unsigned IVAM_TIMER0_COMPA   = 15;
	localparam int unsigned IVAM_SERIAL_PERIPH  = 18;
	localparam int unsigned IVAM_UART0_RX       = 19;
	localparam int unsigned IVAM_ANALOG_CMP     = 22;
	localparam int unsigned IVAM_CONV_DONE      = 23;
	localparam int unsigned IVAM_NV_DATA_READY  = 24;
	localparam int unsigned IVAM_TWO_WIRE       = 25;
	localparam int unsigned IVAM_PROG_STORE_RDY = 26;
	localparam int unsigned IVAM_UART1_RX       = 27;

	// ====================================================================
	// fetch request handed to the core
	typedef struct packed {
		logic                  valid;
		logic                  is_reset;
		logic [IVAM_IDX_W-1:0] index;
		logic [15:0]           addr;
	} ivam_fetch_t;

	typedef enum logic [1:0] {
		IVAM_ST_RESET,
		IVAM_ST_RUN
	} ivam_state_t;

endpackage

// ### ivam_pick.sv
// Purpose: lowest-numbered pending request finder
// Assumes: request bit 0 is the highest priority
// Notes:   registered result, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module ivam_pick
	import ivam_pkg::*;
#(
	parameter int unsigned N = IVAM_NUM_IRQ
) (
	input  wire logic                  core_clk,
	input  wire logic                  srst,
	input  wire logic [N-1:0]          req,
	output logic                       hit_r,
	output logic [IVAM_IDX_W-1:0]      idx_r
);

	logic                  hit_nxt;
	logic [IVAM_IDX_W-1:0] idx_nxt;

	// ====================================================================
	// priority search, downward so lowest index wins
	always_comb begin
		hit_nxt = 1'b0;
		idx_nxt = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				hit_nxt = 1'b1;
				idx_nxt = IVAM_IDX_W'(i); // R10
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hit_r <= 1'b0;
			idx_r <= '0;
		end else begin
			hit_r <= hit_nxt;
			idx_r <= idx_nxt;
		end
	end

endmodule
`default_nettype wire

// ### ivam_core_model.sv
// Purpose: core model that acknowledges presented vectors
// Assumes: ack is taken on an edge with valid high
// Notes:   wait_cyc sets how slowly the core answers
`timescale 1ns/1ps
`default_nettype none
module ivam_core_model
	import ivam_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire ivam_fetch_t fetch_r,
	input  wire logic [1:0]  wait_cyc,
	output logic             fetch_ack
);
	logic [1:0] cnt;
	// ====================================================================
	// one ack per vector; dropped at once so a vector is never taken twice
	always @(posedge core_clk) begin
		if (srst || !fetch_r.valid || fetch_ack) begin
			cnt <= 2'h0;
			fetch_ack <= 1'b0;
		end else if (cnt == wait_cyc) begin
			fetch_ack <= 1'b1;
		end else begin
			cnt <= cnt + 2'h1;
		end
	end
endmodule
`default_nettype wire

// ### interrupt_vector_address_map_test.sv
// Purpose: self-checking bench for the vector address map
// Assumes: sources drop their request once the vector is taken
// Notes:   all four fuse and select combinations are run
`timescale 1ns/1ps
`default_nettype none
module interrupt_vector_address_map_test
	import ivam_pkg::*;
;
	localparam logic [15:0] BB = 16'h7C00;
	logic        core_clk = 1'b0;
	logic        srst     = 1'b1;
	logic        fuse     = 1'b1;
	logic        sel      = 1'b0;
	logic [29:0] irq_req  = 30'h0;
	logic [29:0] raise    = 30'h0;
	logic [1:0]  wait_cyc = 2'h0;
	logic        fetch_ack;
	ivam_fetch_t fetch_r;
	ivam_fetch_t q[$];
	int          fails = 0;
	int          comparisons = 0;

	initial forever #20 core_clk = ~core_clk;

	ivam_top #(.BOOT_BASE(BB)) ivam_top_inst (.core_clk(core_clk), .srst(srst),
		.boot_reset_fuse(fuse), .vector_table_select(sel), .irq_req(irq_req),
		.fetch_ack(fetch_ack), .fetch_r(fetch_r));
	ivam_core_model ivam_core_model_inst (.core_clk(core_clk), .srst(srst),
		.fetch_r(fetch_r), .wait_cyc(wait_cyc), .fetch_ack(fetch_ack));

	// ====================================================================
	// expectations
	task automatic exp_vec(input logic rst, input logic [15:0] addr, input int i);
		ivam_fetch_t e;
		e = '0;
		e.valid = 1'b1;
		e.is_reset = rst;
		e.index = rst ? 5'h00 : i[4:0];
		e.addr = addr;
		q.push_back(e);
	endtask

	// one-cycle strobe; the source process below owns irq_req
	task automatic raise_req(input logic [29:0] m);
		raise <= m;
		@(posedge core_clk);
		raise <= 30'h0;
	endtask

	task automatic drain();
		int n;
		n = 0;
		while (q.size() != 0 && n < 60) begin
			@(posedge core_clk);
			n++;
		end
		if (q.size() != 0) begin
			fails++;
			$display("mismatch t=%0t exp=%h got=%h", $time, 0, q.size());
			q.delete();
		end
		repeat (2) @(posedge core_clk);
		// nothing may be fetched while no source is pending
		@(negedge core_clk);
		comparisons++;
		if (fetch_r.valid !== 1'b0) begin
			fails++;
			$display("mismatch t=%0t exp=%h got=%h", $time, 1'b0, fetch_r.valid);
		end
		@(posedge core_clk);
	endtask

	task automatic test_done();
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ====================================================================
	// monitor: oldest note against each taken vector
	always @(posedge core_clk) begin
		ivam_fetch_t e;
		ivam_fetch_t g;
		logic [29:0] clr;
		clr = 30'h0;
		if (!srst && fetch_r.valid === 1'b1 && fetch_ack === 1'b1) begin
			g = fetch_r;
			if (g.is_reset === 1'b1)
				g.index = 5'h00;
			e = (q.size() != 0) ? q.pop_front() : '1;
			comparisons++;
			if (g !== e) begin
				fails++;
				$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
			end
			// source clears its own request once serviced
			if (g.is_reset === 1'b0)
				clr[g.index] = 1'b1;
		end
		// a raise in the cycle of a take wins
		irq_req <= (irq_req & ~clr) | raise;
	end

	// ====================================================================
	// stimulus
	initial begin
		int a;
		int b;
		void'($urandom(96062));
		for (int c = 0; c < 4; c++) begin
			@(posedge core_clk);
			srst <= 1'b1;
			fuse <= ~c[1];
			sel <= c[0];
			a = $urandom_range(28, 0);
			b = $urandom_range(29, a + 1);
			// pending pair during reset: reset first, then lower vector
			raise_req((30'h1 << a) | (30'h1 << b));
			exp_vec(1'b1, c[1] ? BB : 16'h0000, 0);
			exp_vec(1'b0, (c[0] ? BB : 16'h0000) + 16'h0002 + 16'(2 * a), a);
			exp_vec(1'b0, (c[0] ? BB : 16'h0000) + 16'h0002 + 16'(2 * b), b);
			repeat (6) @(posedge core_clk);
			srst <= 1'b0;
			drain();
			for (int i = 0; i < 30; i++) begin
				wait_cyc <= 2'($urandom_range(3, 0));
				raise_req(30'h1 << i);
				exp_vec(1'b0, (c[0] ? BB : 16'h0000) + 16'h0002 + 16'(2 * i), i);
				drain();
			end
		end
		test_done();
	end

	initial begin
		#(40 * 5000);
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
